// ==== mlb_bank.v ====
// Purpose: Register bank of a voltage and temperature monitor: masks, results, DAC codes, limits, offsets.
// Assumes: Register port and converter strobes come from logic on I_CLK; one access per cycle.
// Notes:   Read data appear one cycle after the read strobe; the alert output is active low.
`timescale 1ns/1ns
`include "mlb_regs.vh"

// Function
// - Register 0x18 bits 7:0 suppress under flags of inputs 9..16, bit 0 is input 9.
// - All bits of registers 0x18 and 0x19 reset to one.
// - Register 0x19 holds diode, temperature over and under masks in bits 4:0.
// - Sixteen read-only 10-bit result registers at 0x1A..0x29, reset to zero.
// - Twelve read-write 12-bit DAC code registers, reset zero, upper bits read zero.
// - Sixteen 10-bit input upper thresholds reset to full scale 0x3FF.
// - Sixteen 10-bit input lower thresholds reset to zero, upper bits read zero.
// - On-chip temperature upper threshold at 0x56 resets to 0x154.
// - Remote temperature upper threshold at 0x58 resets to 0x1B8.
// - Both temperature lower thresholds reset to zero.
// - Signed 8-bit on-chip offset is added to every on-chip temperature result.
// - Signed 8-bit remote offset is added to every remote temperature result.
// - First status read releases alert and refreshes contents; clear shows on next read.
// - Diode fault sets its status bit; its mask gates it onto the alert.
module mlb_bank #(
    parameter NUM_IN  = 16,
    parameter NUM_DAC = 12
) (
    input  wire                    I_CLK,
    input  wire                    I_RST_N,
    input  wire [7:0]              I_REG_ADDR,
    input  wire                    I_REG_WR,
    input  wire                    I_REG_RD,
    input  wire [15:0]             I_REG_WDATA,
    output reg  [15:0]             O_REG_RDATA,
    input  wire                    I_CONV_VALID,
    input  wire [4:0]              I_CONV_CHAN,
    input  wire [9:0]              I_CONV_DATA,
    input  wire                    I_DIODE_FAULT,
    output wire [NUM_DAC*12-1:0]   O_DAC_CODE,
    output wire                    O_ALERT_N
);
    localparam NCH = NUM_IN + 2;
    // The two temperatures sit behind the sixteen inputs, so one comparator
    // array serves all eighteen stored results; their flags go to the temperature status bits.

    // Stored results, thresholds and DAC codes; entries NUM_IN and NUM_IN+1 are the temperatures.
    reg [9:0]  result_q [0:NCH-1];
    reg [9:0]  upper_q  [0:NCH-1];
    reg [9:0]  lower_q  [0:NCH-1];
    reg [11:0] dac_q    [0:NUM_DAC-1];
    reg [7:0]  mask_over_lo_q;
    reg [7:0]  mask_over_hi_q;
    reg [7:0]  mask_under_lo_q;
    reg [7:0]  input_under_mask_hi_q;
    reg [4:0]  temp_fault_mask_q;
    reg [7:0]  onchip_adjust_q;
    reg [7:0]  remote_adjust_q;

    // Sticky flags and the copies that status reads return.
    reg [15:0] over_flag_q;
    reg [15:0] under_flag_q;
    reg [4:0]  temp_flag_q;
    reg [15:0] over_flag_d;
    reg [15:0] under_flag_d;
    reg [4:0]  temp_flag_d;
    reg [15:0] over_shown_q;
    reg [15:0] under_shown_q;
    reg [4:0]  temp_shown_q;

    wire [NCH-1:0] over_w;
    wire [NCH-1:0] under_w;
    // Array decodes: the index is the address less the array base, and the
    // address must also be at or above the base, since the subtraction wraps.
    wire [7:0]     res_idx   = I_REG_ADDR - `MLB_RESULT_BASE;
    wire [7:0]     dac_idx   = I_REG_ADDR - `MLB_DAC_BASE;
    wire [7:0]     upper_idx = I_REG_ADDR - `MLB_UPPER_BASE;
    wire [7:0]     lower_idx = I_REG_ADDR - `MLB_LOWER_BASE;
    wire           in_res    = (I_REG_ADDR >= `MLB_RESULT_BASE) && (res_idx < NUM_IN);
    wire           in_dac    = (I_REG_ADDR >= `MLB_DAC_BASE) && (dac_idx < NUM_DAC);
    wire           in_upper  = (I_REG_ADDR >= `MLB_UPPER_BASE) && (upper_idx < NUM_IN);
    wire           in_lower  = (I_REG_ADDR >= `MLB_LOWER_BASE) && (lower_idx < NUM_IN);

    // Offset addition for temperature results, saturated to the 10-bit code range.
    // The sum is two bits wider than the code: bit 11 marks a result pushed below
    // zero and bit 10 one pushed past full scale. Clamping instead of wrapping keeps
    // a large negative offset from turning a cold reading into an over-limit.
    // Analog inputs carry no offset and pass straight through.
    reg  [7:0]  adj_sel;
    reg  [11:0] adj_sum;
    reg  [9:0]  conv_value;
    always @* begin
        adj_sel = (I_CONV_CHAN == `MLB_CHAN_REMOTE) ? remote_adjust_q : onchip_adjust_q;
        adj_sum = {2'b00, I_CONV_DATA} + {{4{adj_sel[7]}}, adj_sel};
        if (I_CONV_CHAN < `MLB_CHAN_ONCHIP) begin
            conv_value = I_CONV_DATA;
        end else if (adj_sum[11]) begin
            conv_value = 10'h000;
        end else if (adj_sum[10]) begin
            conv_value = 10'h3FF;
        end else begin
            conv_value = adj_sum[9:0];
        end
    end

    // Store each conversion result into its channel slot.
    // Channel numbers at or above NCH are dropped, so a stray strobe cannot
    // write past the end of the array.
    integer r;
    always @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            for (r = 0; r < NCH; r = r + 1) begin
                result_q[r] <= 10'h000;
            end
        end else if (I_CONV_VALID && (I_CONV_CHAN < NCH)) begin
            result_q[I_CONV_CHAN] <= conv_value;
        end
    end

    // Window comparators on the stored, offset-adjusted results.
    // They run every cycle on the stored value, not only on a new conversion,
    // so a limit written past a standing result trips at once.
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : gen_cmp
            mlb_limit_cmp #(
                .W (10)
            ) u_cmp (
                .i_value (result_q[g]),
                .i_upper (upper_q[g]),
                .i_lower (lower_q[g]),
                .o_over  (over_w[g]),
                .o_under (under_w[g])
            );
        end
    endgenerate

    // Register writes; only the documented field bits are kept.
    // Result and status addresses are read-only and fall to the default arm.
    // Reserved upper bits are not stored, so they always read back as zero.
    integer w;
    always @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            mask_over_lo_q        <= `MLB_MASK8_RST;
            mask_over_hi_q        <= `MLB_MASK8_RST;
            mask_under_lo_q       <= `MLB_MASK8_RST;
            input_under_mask_hi_q <= `MLB_MASK8_RST;
            temp_fault_mask_q     <= `MLB_MASK5_RST;
            onchip_adjust_q       <= `MLB_ADJUST_RST;
            remote_adjust_q       <= `MLB_ADJUST_RST;
            for (w = 0; w < NUM_IN; w = w + 1) begin
                upper_q[w] <= `MLB_INPUT_UPPER_RST;
                lower_q[w] <= `MLB_LOWER_RST;
            end
            upper_q[NUM_IN]     <= `MLB_ONCHIP_UPPER_RST;
            upper_q[NUM_IN + 1] <= `MLB_REMOTE_UPPER_RST;
            lower_q[NUM_IN]     <= `MLB_LOWER_RST;
            lower_q[NUM_IN + 1] <= `MLB_LOWER_RST;
            for (w = 0; w < NUM_DAC; w = w + 1) begin
                dac_q[w] <= `MLB_DAC_RST;
            end
        end else if (I_REG_WR) begin
            if (in_dac) begin
                dac_q[dac_idx[3:0]] <= I_REG_WDATA[11:0];
            end
            if (in_upper) begin
                upper_q[upper_idx[4:0]] <= I_REG_WDATA[9:0];
            end
            if (in_lower) begin
                lower_q[lower_idx[4:0]] <= I_REG_WDATA[9:0];
            end
            case (I_REG_ADDR)
                `MLB_MASK_OVER_LO:        mask_over_lo_q        <= I_REG_WDATA[7:0];
                `MLB_MASK_OVER_HI:        mask_over_hi_q        <= I_REG_WDATA[7:0];
                `MLB_MASK_UNDER_LO:       mask_under_lo_q       <= I_REG_WDATA[7:0];
                `MLB_INPUT_UNDER_MASK_HI: input_under_mask_hi_q <= I_REG_WDATA[7:0];
                `MLB_TEMP_FAULT_MASK:     temp_fault_mask_q     <= I_REG_WDATA[4:0];
                `MLB_ONCHIP_UPPER:        upper_q[NUM_IN]       <= I_REG_WDATA[9:0];
                `MLB_ONCHIP_LOWER:        lower_q[NUM_IN]       <= I_REG_WDATA[9:0];
                `MLB_REMOTE_UPPER:        upper_q[NUM_IN + 1]   <= I_REG_WDATA[9:0];
                `MLB_REMOTE_LOWER:        lower_q[NUM_IN + 1]   <= I_REG_WDATA[9:0];
                `MLB_ONCHIP_ADJUST:       onchip_adjust_q       <= I_REG_WDATA[7:0];
                `MLB_REMOTE_ADJUST:       remote_adjust_q       <= I_REG_WDATA[7:0];
                default: begin
                end
            endcase
        end
    end

    // Sticky flags: a read clears its register's flags, but a condition still present sets them again.
    // The clear is applied first and live conditions are ORed in after it, so an
    // event in the same cycle as the clearing read wins and is never lost.
    always @* begin
        over_flag_d  = over_flag_q;
        under_flag_d = under_flag_q;
        temp_flag_d  = temp_flag_q;
        if (I_REG_RD) begin
            case (I_REG_ADDR)
                `MLB_STAT_OVER_LO:  over_flag_d[7:0]   = 8'h00;
                `MLB_STAT_OVER_HI:  over_flag_d[15:8]  = 8'h00;
                `MLB_STAT_UNDER_LO: under_flag_d[7:0]  = 8'h00;
                `MLB_STAT_UNDER_HI: under_flag_d[15:8] = 8'h00;
                `MLB_STAT_TEMP:     temp_flag_d        = 5'h00;
                default: begin
                end
            endcase
        end
        over_flag_d  = over_flag_d | over_w[15:0];
        under_flag_d = under_flag_d | under_w[15:0];
        temp_flag_d[`MLB_BIT_DIODE]        = temp_flag_d[`MLB_BIT_DIODE] | I_DIODE_FAULT;
        temp_flag_d[`MLB_BIT_ONCHIP_OVER]  = temp_flag_d[`MLB_BIT_ONCHIP_OVER] | over_w[NUM_IN];
        temp_flag_d[`MLB_BIT_REMOTE_OVER]  = temp_flag_d[`MLB_BIT_REMOTE_OVER] | over_w[NUM_IN + 1];
        temp_flag_d[`MLB_BIT_ONCHIP_UNDER] = temp_flag_d[`MLB_BIT_ONCHIP_UNDER] | under_w[NUM_IN];
        temp_flag_d[`MLB_BIT_REMOTE_UNDER] = temp_flag_d[`MLB_BIT_REMOTE_UNDER] | under_w[NUM_IN + 1];
    end

    // Flag state and the shown copies, which a status read refreshes after returning the old copy.
    // The shown copy lags the sticky flags by one read: the host sees the old
    // flags first, and a cleared state only on its next read of that register.
    always @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            over_flag_q   <= 16'h0000;
            under_flag_q  <= 16'h0000;
            temp_flag_q   <= 5'h00;
            over_shown_q  <= 16'h0000;
            under_shown_q <= 16'h0000;
            temp_shown_q  <= 5'h00;
        end else begin
            over_flag_q  <= over_flag_d;
            under_flag_q <= under_flag_d;
            temp_flag_q  <= temp_flag_d;
            if (I_REG_RD) begin
                case (I_REG_ADDR)
                    `MLB_STAT_OVER_LO:  over_shown_q[7:0]   <= over_flag_d[7:0];
                    `MLB_STAT_OVER_HI:  over_shown_q[15:8]  <= over_flag_d[15:8];
                    `MLB_STAT_UNDER_LO: under_shown_q[7:0]  <= under_flag_d[7:0];
                    `MLB_STAT_UNDER_HI: under_shown_q[15:8] <= under_flag_d[15:8];
                    `MLB_STAT_TEMP:     temp_shown_q        <= temp_flag_d;
                    default: begin
                    end
                endcase
            end
        end
    end

    // Read data, registered; reserved bits and unmapped addresses read zero.
    // Data stand from the edge that takes the strobe until the next read strobe.
    // Writes never disturb them, so a slow host may sample them at leisure.
    always @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            O_REG_RDATA <= 16'h0000;
        end else if (I_REG_RD) begin
            O_REG_RDATA <= 16'h0000;
            if (in_res) begin
                O_REG_RDATA <= {6'h00, result_q[res_idx[4:0]]};
            end else if (in_dac) begin
                O_REG_RDATA <= {4'h0, dac_q[dac_idx[3:0]]};
            end else if (in_upper) begin
                O_REG_RDATA <= {6'h00, upper_q[upper_idx[4:0]]};
            end else if (in_lower) begin
                O_REG_RDATA <= {6'h00, lower_q[lower_idx[4:0]]};
            end else begin
                case (I_REG_ADDR)
                    `MLB_STAT_OVER_LO:        O_REG_RDATA <= {8'h00, over_shown_q[7:0]};
                    `MLB_STAT_OVER_HI:        O_REG_RDATA <= {8'h00, over_shown_q[15:8]};
                    `MLB_STAT_UNDER_LO:       O_REG_RDATA <= {8'h00, under_shown_q[7:0]};
                    `MLB_STAT_UNDER_HI:       O_REG_RDATA <= {8'h00, under_shown_q[15:8]};
                    `MLB_STAT_TEMP:           O_REG_RDATA <= {11'h000, temp_shown_q};
                    `MLB_MASK_OVER_LO:        O_REG_RDATA <= {8'h00, mask_over_lo_q};
                    `MLB_MASK_OVER_HI:        O_REG_RDATA <= {8'h00, mask_over_hi_q};
                    `MLB_MASK_UNDER_LO:       O_REG_RDATA <= {8'h00, mask_under_lo_q};
                    `MLB_INPUT_UNDER_MASK_HI: O_REG_RDATA <= {8'h00, input_under_mask_hi_q};
                    `MLB_TEMP_FAULT_MASK:     O_REG_RDATA <= {11'h000, temp_fault_mask_q};
                    `MLB_ONCHIP_UPPER:        O_REG_RDATA <= {6'h00, upper_q[NUM_IN]};
                    `MLB_ONCHIP_LOWER:        O_REG_RDATA <= {6'h00, lower_q[NUM_IN]};
                    `MLB_REMOTE_UPPER:        O_REG_RDATA <= {6'h00, upper_q[NUM_IN + 1]};
                    `MLB_REMOTE_LOWER:        O_REG_RDATA <= {6'h00, lower_q[NUM_IN + 1]};
                    `MLB_ONCHIP_ADJUST:       O_REG_RDATA <= {8'h00, onchip_adjust_q};
                    `MLB_REMOTE_ADJUST:       O_REG_RDATA <= {8'h00, remote_adjust_q};
                    default:                  O_REG_RDATA <= 16'h0000;
                endcase
            end
        end
    end

    // DAC codes leave straight from their registers.
    // No extra stage: a written code reaches its output at the write edge.
    genvar d;
    generate
        for (d = 0; d < NUM_DAC; d = d + 1) begin : gen_dac
            assign O_DAC_CODE[d*12 +: 12] = dac_q[d];
        end
    endgenerate

    // Alert: any sticky flag whose mask bit is clear pulls the output low.
    // All masks reset to one, so the output stays released after reset until
    // software clears a mask bit whose flag is set.
    // It is formed from registers only, so bus activity cannot make it glitch.
    wire alert_w = |(over_flag_q & ~{mask_over_hi_q, mask_over_lo_q})
                 | |(under_flag_q & ~{input_under_mask_hi_q, mask_under_lo_q})
                 | |(temp_flag_q & ~temp_fault_mask_q);
    assign O_ALERT_N = ~alert_w;

endmodule

// ==== mlb_bank_bench.sv ====
// Purpose: Self-checking bench for the monitor limit and mask bank against a register model.
// Assumes: 100 MHz clock; inputs change 1 ns after the rising edge.
// Notes:   Directed alert cases use a table; register contents are scanned after each phase but the alert cases.
`timescale 1ns/1ns
module mlb_bank_bench;
    reg            clk, rst_n, cv, df;
    reg  [4:0]     cch;
    reg  [9:0]     cdat;
    reg  [15:0]    rv;
    wire [7:0]     addr;
    wire           wr, rd, alert_n;
    wire [15:0]    wdata, rdata;
    wire [143:0]   dac;
    logic [15:0]   exp_reg [0:255];
    logic [15:0]   cs [0:7][0:6] = '{'{8'h5A, 16'hFE, 16, 10'h155, 8'h19, 16'h17, 0},
        '{8'h5A, 16'h02, 16, 10'h153, 8'h19, 16'h17, 1}, '{8'h5B, 16'h05, 17, 10'h1B5, 8'h19, 16'h1B, 1},
        '{8'h5B, 16'h80, 17, 10'h1B5, 8'h19, 16'h1B, 0}, '{8'h4E, 16'h100, 8, 10'h050, 8'h18, 16'hFE, 1},
        '{8'h4E, 16'h100, 8, 10'h050, 8'h18, 16'hFD, 0}, '{8'h57, 16'h100, 16, 10'h0F0, 8'h19, 16'h1D, 1},
        '{8'h59, 16'h100, 17, 10'h050, 8'h19, 16'h1E, 1}};
    integer        miscompares, n_checks, a, k, seed_dummy;

    mlb_host host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata));
    mlb_bank uut (.I_CLK(clk), .I_RST_N(rst_n), .I_REG_ADDR(addr), .I_REG_WR(wr), .I_REG_RD(rd),
        .I_REG_WDATA(wdata), .O_REG_RDATA(rdata), .I_CONV_VALID(cv), .I_CONV_CHAN(cch),
        .I_CONV_DATA(cdat), .I_DIODE_FAULT(df), .O_DAC_CODE(dac), .O_ALERT_N(alert_n));

    // Free-running 100 MHz clock.
    always #5 clk = ~clk;

    // Writable bits of each register; read-only and unmapped places give zero.
    function automatic [15:0] wmask(input integer r);
        if ((r >= 8'h15 && r <= 8'h18) || r == 8'h5A || r == 8'h5B) wmask = 16'h00FF;
        else if (r == 8'h19) wmask = 16'h001F;
        else if (r >= 8'h2A && r <= 8'h35) wmask = 16'h0FFF;
        else if (r >= 8'h36 && r <= 8'h59) wmask = 16'h03FF;
        else wmask = 16'h0000;
    endfunction

    task automatic check(input [15:0] got, input [15:0] want, input [7:0] r);
        begin
            n_checks = n_checks + 1;
            if (got !== want) begin
                miscompares = miscompares + 1;
                $display("Error at %0t: place %h gave %h, model %h", $time, r, got, want);
            end
        end
    endtask

    // Reset for 8 cycles and load the model with the documented defaults.
    task automatic do_reset;
        integer r;
        begin
            rst_n = 1'b0;
            repeat (8) @(posedge clk);
            #1;
            rst_n = 1'b1;
            for (r = 0; r < 256; r = r + 1) exp_reg[r] = 16'h0000;
            for (r = 8'h15; r <= 8'h18; r = r + 1) exp_reg[r] = 16'h00FF;
            for (r = 8'h36; r <= 8'h45; r = r + 1) exp_reg[r] = 16'h03FF;
            exp_reg[8'h19] = 16'h001F;
            exp_reg[8'h56] = 16'h0154;
            exp_reg[8'h58] = 16'h01B8;
        end
    endtask

    // Read every place from the first mask to one past the last offset, then the DAC outputs.
    task automatic scan;
        integer r;
        begin
            for (r = 8'h15; r <= 8'h5C; r = r + 1) begin
                host.read_reg(r[7:0], rv);
                check(rv, exp_reg[r], r[7:0]);
            end
            for (r = 0; r < 12; r = r + 1) check({4'h0, dac[12*r +: 12]}, exp_reg[8'h2A + r], 8'h2A + 8'(r));
        end
    endtask

    task automatic conv(input [4:0] ch, input [9:0] v);
        begin
            @(posedge clk);
            #1;
            cv = 1'b1;
            cch = ch;
            cdat = v;
            @(posedge clk);
            #1;
            cv = 1'b0;
            cdat = ~v;
        end
    endtask

    // Two reads of each status register leave only flags whose condition still holds.
    task automatic flush;
        integer s;
        begin
            for (s = 0; s < 10; s = s + 1) host.read_reg(8'h10 + 8'(s % 5), rv);
        end
    endtask

    task give_verdict;
        begin
            $display("Checks %0d, miscompares %0d", n_checks, miscompares);
            if (miscompares == 0 && n_checks > 0) $display("Regression OK");
            else $display("Regression broken");
            $finish;
        end
    endtask

    // Main sequence: defaults, random writes, conversions, second reset, alert cases.
    initial begin
        clk = 1'b0; rst_n = 1'b0; cv = 1'b0; df = 1'b0; cch = 5'd0; cdat = 10'h000; rv = 16'h0000;
        miscompares = 0;
        n_checks = 0;
        seed_dummy = $urandom(32'h24f59f79);
        do_reset;
        scan;
        for (a = 8'h15; a <= 8'h5C; a = a + 1) begin
            k = $urandom;
            host.write_reg(a[7:0], k[15:0]);
            if (wmask(a) != 16'h0000) exp_reg[a] = k[15:0] & wmask(a);
        end
        scan;
        for (k = 0; k < 19; k = k + 1) begin
            a = $urandom;
            conv(k[4:0], a[9:0]);
            if (k < 16) exp_reg[8'h1A + k] = {6'h00, a[9:0]};
        end
        scan;
        do_reset;
        scan;
        for (k = 0; k < 8; k = k + 1) begin
            host.write_reg(cs[k][0][7:0], cs[k][1]);
            conv(cs[k][2][4:0], cs[k][3][9:0]);
            flush;
            host.write_reg(cs[k][4][7:0], cs[k][5]);
            repeat (2) @(posedge clk);
            #1;
            check({15'h0, alert_n}, {15'h0, ~cs[k][6][0]}, 8'hA0 + 8'(k));
            host.write_reg(cs[k][4][7:0], (cs[k][4] == 16'h19) ? 16'h001F : 16'h00FF);
        end
        // Diode fault: unmask it, then see the release on the first read and the clear on the second.
        df = 1'b1;
        host.read_reg(8'h14, rv);
        host.write_reg(8'h19, 16'h000F);
        check({15'h0, alert_n}, 16'h0000, 8'hB0);
        df = 1'b0;
        host.read_reg(8'h14, rv);
        check(rv & 16'h0010, 16'h0010, 8'h14);
        @(posedge clk);
        #1;
        check({15'h0, alert_n}, 16'h0001, 8'hB1);
        host.read_reg(8'h14, rv);
        check(rv & 16'h0010, 16'h0000, 8'h14);
        give_verdict;
    end

    // Watchdog well beyond the expected run of under fifteen hundred cycles.
    initial begin
        #500000;
        miscompares = miscompares + 1;
        $display("Error at %0t: watchdog expired", $time);
        give_verdict;
    end
endmodule

bind mlb_bank mlb_monitor #(.NUM_DAC(NUM_DAC)) chk (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_REG_ADDR(I_REG_ADDR),
    .I_REG_WR(I_REG_WR), .I_REG_RD(I_REG_RD), .I_REG_WDATA(I_REG_WDATA), .O_REG_RDATA(O_REG_RDATA),
    .I_CONV_VALID(I_CONV_VALID), .I_DIODE_FAULT(I_DIODE_FAULT), .O_DAC_CODE(O_DAC_CODE), .O_ALERT_N(O_ALERT_N));

// ==== mlb_host.sv ====
// Purpose: Host controller model that reaches the bank through its register port.
// Assumes: Strobes are one-cycle pulses driven just after the rising edge.
// Notes:   Inserts a random idle gap before each access; released lines show inverted data.
`timescale 1ns/1ns
module mlb_host (
    input  wire        i_clk,
    input  wire [15:0] i_rdata,
    output reg  [7:0]  o_addr,
    output reg         o_wr,
    output reg         o_rd,
    output reg  [15:0] o_wdata
);
    // Idle bus at time zero.
    initial begin
        o_addr = 8'h00;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_wdata = 16'h0000;
    end

    // One write: strobe for one edge, then scramble the released lines.
    task automatic write_reg(input [7:0] a, input [15:0] d);
        begin
            repeat ($urandom_range(2, 1)) @(posedge i_clk);
            #1;
            o_addr = a;
            o_wdata = d;
            o_wr = 1'b1;
            @(posedge i_clk);
            #1;
            o_wr = 1'b0;
            o_addr = ~a;
            o_wdata = ~d;
        end
    endtask

    // One read: data are taken just after the edge that takes the strobe.
    task automatic read_reg(input [7:0] a, output [15:0] d);
        begin
            repeat ($urandom_range(2, 1)) @(posedge i_clk);
            #1;
            o_addr = a;
            o_rd = 1'b1;
            @(posedge i_clk);
            #1;
            o_rd = 1'b0;
            o_addr = ~a;
            d = i_rdata;
        end
    endtask
endmodule

// ==== mlb_limit_cmp.v ====
// Purpose: Window comparison of one stored result against its upper and lower thresholds.
// Assumes: All three values are unsigned codes of the same width.
// Notes:   Purely combinational; the caller makes the flags sticky.
`timescale 1ns/1ns
module mlb_limit_cmp #(
    parameter W = 10
) (
    input  wire [W-1:0] i_value,
    input  wire [W-1:0] i_upper,
    input  wire [W-1:0] i_lower,
    output wire         o_over,
    output wire         o_under
);
    // Strict comparisons, so a result equal to a threshold trips nothing.
    assign o_over  = (i_value > i_upper);
    assign o_under = (i_value < i_lower);
endmodule

// ==== mlb_monitor.sv ====
// Purpose: Concurrent checks on the ports of the monitor limit and mask bank.
// Assumes: One clock domain; reset is asynchronous and active low.
// Notes:   Attached by bind from the bench top file; prints nothing but failures.
`timescale 1ns/1ns
module mlb_monitor #(
    parameter NUM_DAC = 12
) (
    input wire                  I_CLK,
    input wire                  I_RST_N,
    input wire [7:0]            I_REG_ADDR,
    input wire                  I_REG_WR,
    input wire                  I_REG_RD,
    input wire [15:0]           I_REG_WDATA,
    input wire [15:0]           O_REG_RDATA,
    input wire                  I_CONV_VALID,
    input wire                  I_DIODE_FAULT,
    input wire [NUM_DAC*12-1:0] O_DAC_CODE,
    input wire                  O_ALERT_N
);
    // All checks sample on the rising edge and rest while reset is low.
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RST_N);

    // Masks come out of reset set, so nothing may alert and no DAC code may be loaded.
    reset_quiet_a: assert property ($rose(I_RST_N) |-> O_ALERT_N && (O_DAC_CODE == '0))
        else $error("alert or DAC code not idle after reset");
    read_hold_a: assert property (!I_REG_RD |=> $stable(O_REG_RDATA))
        else $error("read data moved without a read strobe");
    dac_nibble_a: assert property (I_REG_RD |=> O_REG_RDATA[15:12] == 4'h0)
        else $error("read data bits 15:12 not zero");
    ten_bit_a: assert property (I_REG_RD && (I_REG_ADDR inside {[8'h1A:8'h29], [8'h36:8'h59]})
        |=> O_REG_RDATA[15:10] == 6'h00) else $error("ten bit register shows upper bits");
    eight_bit_a: assert property (I_REG_RD && (I_REG_ADDR inside {[8'h15:8'h18], 8'h5A, 8'h5B})
        |=> O_REG_RDATA[15:8] == 8'h00) else $error("eight bit register shows upper bits");
    fault_mask_a: assert property (I_REG_RD && I_REG_ADDR == 8'h19 |=> O_REG_RDATA[15:5] == 11'h000)
        else $error("temperature mask shows bits 15:5");
    dac_load_a: assert property (I_REG_WR && (I_REG_ADDR inside {[8'h2A:8'h35]})
        |=> {4'h0, O_DAC_CODE[12*($past(I_REG_ADDR)-8'h2A) +: 12]} == ($past(I_REG_WDATA) & 16'h0FFF))
        else $error("DAC code does not follow its write");
    dac_hold_a: assert property (!I_REG_WR |=> $stable(O_DAC_CODE))
        else $error("DAC code changed without a write");
    // An alert needs a cause: a mask or limit write, a stored result, or a diode fault.
    alert_cause_a: assert property ($fell(O_ALERT_N) |-> $past(I_REG_WR) || $past(I_REG_WR, 2)
        || $past(I_CONV_VALID, 2) || $past(I_DIODE_FAULT)) else $error("alert asserted without cause");
    alert_release_a: assert property ($rose(O_ALERT_N) |-> $past(I_REG_RD) || $past(I_REG_WR))
        else $error("alert released without read or mask write");
endmodule

// ==== mlb_regs.vh ====
// Purpose: Register offsets, field positions, reset values and channel numbers of the monitor limit and mask bank.
// Assumes: Offsets are register indices on the 8-bit register port of the serial front end.
// Notes:   Include by bare name; definitions only.
`ifndef MLB_REGS_VH
`define MLB_REGS_VH

// Status registers, read to release the alert.
`define MLB_STAT_OVER_LO     8'h10
`define MLB_STAT_OVER_HI     8'h11
`define MLB_STAT_UNDER_LO    8'h12
`define MLB_STAT_UNDER_HI    8'h13
`define MLB_STAT_TEMP        8'h14

// Mask registers.
`define MLB_MASK_OVER_LO     8'h15
`define MLB_MASK_OVER_HI     8'h16
`define MLB_MASK_UNDER_LO    8'h17
`define MLB_INPUT_UNDER_MASK_HI 8'h18
`define MLB_TEMP_FAULT_MASK  8'h19

// Register arrays, first index of each.
`define MLB_RESULT_BASE      8'h1A
`define MLB_DAC_BASE         8'h2A
`define MLB_UPPER_BASE       8'h36
`define MLB_LOWER_BASE       8'h46

// Temperature registers.
`define MLB_ONCHIP_UPPER     8'h56
`define MLB_ONCHIP_LOWER     8'h57
`define MLB_REMOTE_UPPER     8'h58
`define MLB_REMOTE_LOWER     8'h59
`define MLB_ONCHIP_ADJUST    8'h5A
`define MLB_REMOTE_ADJUST    8'h5B

// Bit positions in the temperature fault mask and status.
`define MLB_BIT_DIODE        4
`define MLB_BIT_ONCHIP_OVER  3
`define MLB_BIT_REMOTE_OVER  2
`define MLB_BIT_ONCHIP_UNDER 1
`define MLB_BIT_REMOTE_UNDER 0

// Reset values.
`define MLB_MASK8_RST        8'hFF
`define MLB_MASK5_RST        5'h1F
`define MLB_INPUT_UPPER_RST  10'h3FF
`define MLB_ONCHIP_UPPER_RST 10'h154
`define MLB_REMOTE_UPPER_RST 10'h1B8
`define MLB_LOWER_RST        10'h000
`define MLB_DAC_RST          12'h000
`define MLB_ADJUST_RST       8'h00

// Converter channel numbers for the two temperatures.
`define MLB_CHAN_ONCHIP      5'd16
`define MLB_CHAN_REMOTE      5'd17

`endif
